// ---- hdl/cmd_timer.sv ----
// Command time base and duration counter for write and erase pulses.
// Assumes start is a one-cycle pulse from the sequencer on the same clock.
`timescale 1ns/1ps
module cmd_timer
  import flash_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] scaler,
  input wire logic [13:0] limit,
  output logic done
);

  logic [7:0] phase;
  logic [13:0] count;
  logic running;

  // scaled time base
  // A phase accumulator carries out at clock*(scaler+1)/256 with no divider jitter build-up.
  wire [8:0] phase_sum = {1'b0, phase} + {1'b0, scaler} + 9'h001;
  wire tick = phase_sum[8];
  wire [13:0] next_count = count + 14'h0001;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 8'h00;
      count <= 14'h0000;
      running <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      phase <= 8'h00;
      count <= 14'h0000;
      running <= 1'b1;
      done <= 1'b0;
    end else begin
      phase <= phase_sum[7:0];
      done <= running && tick && next_count == limit;
      if (running && tick) begin
        count <= next_count;
        running <= next_count != limit;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  done_at_limit_a: assert property (done |-> $past(count) == limit - 14'h0001)
    else $error("timer finished before reaching its limit");
  tick_rate_a: assert property (scaler == 8'hFF && running |-> tick)
    else $error("full scale time base missed a tick");

endmodule

// ---- hdl/flash_cmd_ctrl.sv ----
// Flash command controller: special registers, command sequencer and fetch path.
// Assumes a flash macro that returns read data one clock after flash_read and a
// CPU that drives its special register port on ref_clk and honours cpu_stall.
`timescale 1ns/1ps

// How it works
// - The CPU is stalled from the command write until the command has fully finished.
// - A 64K main array in 1024-byte sectors and a 256-byte information block are served.
// - Program fetches go straight to the flash whenever no command is running.
// - The failure flag is unaffected by reads and cleared only when a new command is issued.
// - A target beyond the array, or a write or erase inside a protected region, sets the failure flag.
// - A 3-bit select picks write lengths of 55 to 89 and erase lengths of 5435 to 8889 ticks.
// - The address is top:high:low address bytes and data moves through the data register.
// - Erase clears a whole sector chosen by the high address bits alone.
// - Writes and erases into either protection zone are skipped and flagged as failed.
// - Outside programmer mode, information block writes below offset 0x40 are refused and flagged as failed.
// - The manufacturer bytes may only be modified in external programmer mode.
// - The time base is the clock times scaler plus one over 256, best set near 2 MHz.
// - One zone runs up from address zero to the low bound within the lower 32KB, one from page 0x80 ORed with the high bound to the top.
// - The low bound counts 256-byte pages and resets to 0xFF so the low region is protected.
// - The high bound counts 256-byte pages and resets to zero so the upper 32KB is protected.
module flash_cmd_ctrl
  import flash_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [15:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic cpu_stall,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  output logic [7:0] fetch_data,
  input wire logic writer_mode,
  output logic [15:0] flash_addr,
  output logic flash_ifb,
  output logic flash_read,
  output logic flash_prog,
  output logic flash_erase,
  output logic [7:0] flash_wdata,
  input wire logic [7:0] flash_rdata
);

  logic rst_q1;
  logic rst_n;
  logic writer_q1;
  logic writer_q;
  logic [7:0] flash_address_top;
  logic [7:0] flash_address_high;
  logic [7:0] flash_address_low;
  logic [7:0] flash_data;
  logic [7:0] command_clock_scaler;
  logic [7:0] low_zone_bound;
  logic [7:0] high_zone_bound;
  logic [4:0] cmd_code;
  logic [2:0] command_timeout_select;
  logic fail;
  logic write_verify_mismatch;
  logic fetch_pend;
  logic fetch_take;
  logic timer_done;
  state_t state;
  state_t next_state;

  // The reset is released through two flops so every register leaves reset on the same edge.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // The programmer-mode pin is asynchronous to ref_clk.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      writer_q1 <= 1'b0;
      writer_q <= 1'b0;
    end else begin
      writer_q1 <= writer_mode;
      writer_q <= writer_q1;
    end
  end

  // Register port decode; writes are only taken while idle because the CPU is stalled otherwise.
  wire idle = state == ST_IDLE;
  wire wr_ok = sfr_wr && idle;
  wire issue = wr_ok && sfr_addr == OFS_COMMAND;
  wire [7:0] command_view = {write_verify_mismatch, 1'b0, fail, cmd_code};

  wire [23:0] target = {flash_address_top, flash_address_high, flash_address_low};

  wire is_main_read = cmd_code == CMD_MAIN_READ;
  wire is_main_write = cmd_code == CMD_MAIN_WRITE;
  wire is_erase = cmd_code == CMD_MAIN_ERASE;
  wire is_ifb_read = cmd_code == CMD_IFB_READ;
  wire is_ifb_write = cmd_code == CMD_IFB_WRITE;
  wire is_ifb = is_ifb_read || is_ifb_write;
  wire is_read = is_main_read || is_ifb_read;
  wire is_write = is_main_write || is_ifb_write;
  wire cmd_valid = is_read || is_write || is_erase;

  wire over_range = is_ifb ? (|target[23:8]) : (|target[23:16]);

  // low and high protection zones in pages
  // An erase spans four pages, so its first page is checked against the low zone and its last page against the high zone.
  wire [7:0] page_lo = is_erase ? {target[15:SECTOR_BITS], PAGE_FIRST} : target[15:8];
  wire [7:0] page_hi = is_erase ? {target[15:SECTOR_BITS], PAGE_LAST} : target[15:8];
  wire low_hit = !page_lo[7] && page_lo < low_zone_bound;
  wire [7:0] high_start = HIGH_ZONE_BASE | high_zone_bound;
  wire high_hit = page_hi >= high_start;

  wire main_protected = (is_main_write || is_erase) && (low_hit || high_hit);

  wire ifb_locked = is_ifb_write && target[7:0] < IFB_USER_FIRST && !writer_q;
  wire reject = !cmd_valid || over_range || main_protected || ifb_locked;

  wire [13:0] limit = is_erase ? ERASE_TICKS[command_timeout_select] : WRITE_TICKS[command_timeout_select];
  wire timer_start = state == ST_CHECK && !reject && (is_write || is_erase);

  // Sequencer next state.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (issue) begin
          next_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (reject) begin
          next_state = ST_ERASE_DONE;
        end else if (is_read) begin
          next_state = ST_READ;
        end else begin
          next_state = ST_PROG;
        end
      end
      ST_READ: next_state = ST_READ_WAIT;
      ST_READ_WAIT: next_state = ST_ERASE_DONE;
      ST_PROG: begin
        if (timer_done) begin
          next_state = is_erase ? ST_ERASE_DONE : ST_VERIFY;
        end
      end
      ST_VERIFY: next_state = ST_VERIFY_WAIT;
      ST_VERIFY_WAIT: next_state = ST_ERASE_DONE;
      ST_ERASE_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  wire next_idle = next_state == ST_IDLE;
  wire next_fetch = next_idle && fetch_req;
  wire [15:0] cmd_addr = is_erase ? {target[15:SECTOR_BITS], {SECTOR_BITS{1'b0}}} : target[15:0];
  wire [15:0] next_flash_addr = next_idle ? fetch_addr : cmd_addr;
  wire next_flash_read = next_fetch || next_state == ST_READ || next_state == ST_VERIFY;
  wire next_flash_prog = next_state == ST_PROG && is_write;
  wire next_flash_erase = next_state == ST_PROG && is_erase;

  // Read-back mux; unmapped addresses read as zero.
  wire [7:0] next_sfr_rdata =
    sfr_addr == OFS_ADDR_TOP ? flash_address_top :
    sfr_addr == OFS_COMMAND ? command_view :
    sfr_addr == OFS_DATA ? flash_data :
    sfr_addr == OFS_ADDR_HIGH ? flash_address_high :
    sfr_addr == OFS_ADDR_LOW ? flash_address_low :
    sfr_addr == OFS_SCALER ? command_clock_scaler :
    sfr_addr == OFS_LOW_BOUND ? low_zone_bound :
    sfr_addr == OFS_HIGH_BOUND ? high_zone_bound : 8'h00;

  // Software-written registers.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_address_top <= RST_ADDR;
      flash_address_high <= RST_ADDR;
      flash_address_low <= RST_ADDR;
      command_clock_scaler <= RST_SCALER;
      low_zone_bound <= RST_LOW_BOUND;
      high_zone_bound <= RST_HIGH_BOUND;
      cmd_code <= RST_CMD_CODE;
      command_timeout_select <= RST_TIMEOUT_SEL;
    end else if (wr_ok) begin
      if (sfr_addr == OFS_ADDR_TOP) flash_address_top <= sfr_wdata;
      if (sfr_addr == OFS_ADDR_HIGH) flash_address_high <= sfr_wdata;
      if (sfr_addr == OFS_ADDR_LOW) flash_address_low <= sfr_wdata;
      if (sfr_addr == OFS_SCALER) command_clock_scaler <= sfr_wdata;
      if (sfr_addr == OFS_LOW_BOUND) low_zone_bound <= sfr_wdata;
      if (sfr_addr == OFS_HIGH_BOUND) high_zone_bound <= sfr_wdata;
      if (issue) begin
        cmd_code <= sfr_wdata[4:0];
        command_timeout_select <= sfr_wdata[7:CMD_SEL_LSB];
      end
    end
  end

  // data register path
  // A read command overwrites the data register so software finds the byte where it wrote one.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_data <= RST_DATA;
    end else if (state == ST_READ_WAIT) begin
      flash_data <= flash_rdata;
    end else if (wr_ok && sfr_addr == OFS_DATA) begin
      flash_data <= sfr_wdata;
    end
  end

  // failure flag and read-back compare
  // Both flags are cleared by a new command and can only be set while that command runs.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fail <= 1'b0;
      write_verify_mismatch <= 1'b0;
    end else if (issue) begin
      fail <= 1'b0;
      write_verify_mismatch <= 1'b0;
    end else begin
      if (state == ST_CHECK && reject) fail <= 1'b1;
      if (state == ST_VERIFY_WAIT && flash_rdata != flash_data) write_verify_mismatch <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cpu_stall <= 1'b0;
    end else begin
      state <= next_state;
      cpu_stall <= !next_idle;
    end
  end

  // Flash macro outputs and CPU read data, all registered.
  // The macro answers one edge after it samples the strobe, so fetch data is taken two edges after the request.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_addr <= 16'h0000;
      flash_ifb <= 1'b0;
      flash_read <= 1'b0;
      flash_prog <= 1'b0;
      flash_erase <= 1'b0;
      flash_wdata <= 8'h00;
      fetch_pend <= 1'b0;
      fetch_take <= 1'b0;
      fetch_data <= 8'h00;
      sfr_rdata <= 8'h00;
    end else begin
      flash_addr <= next_flash_addr;
      flash_ifb <= !next_idle && is_ifb;
      flash_read <= next_flash_read;
      flash_prog <= next_flash_prog;
      flash_erase <= next_flash_erase;
      flash_wdata <= flash_data;
      fetch_pend <= next_fetch;
      fetch_take <= fetch_pend;
      if (fetch_take) fetch_data <= flash_rdata;
      if (sfr_rd) sfr_rdata <= next_sfr_rdata;
    end
  end

  cmd_timer u_timer (
    .clk(ref_clk),
    .rst_n(rst_n),
    .start(timer_start),
    .scaler(command_clock_scaler),
    .limit(limit),
    .done(timer_done)
  );

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_issue;
    issue ##1 state == ST_CHECK;
  endsequence

  sequence s_refused;
    state == ST_CHECK && reject ##1 state == ST_ERASE_DONE && fail;
  endsequence

  stall_on_issue_a: assert property (s_issue |-> cpu_stall)
    else $error("cpu not stalled after command issue");
  stall_release_a: assert property ($fell(cpu_stall) |-> $past(state) == ST_ERASE_DONE)
    else $error("cpu released before the command finished");
  fetch_pass_a: assert property (idle && !issue && fetch_req |=> flash_read && flash_addr == $past(fetch_addr))
    else $error("idle fetch did not reach the flash");
  fail_steady_a: assert property (idle && !issue |=> $stable(fail))
    else $error("fail flag changed without a new command");
  refuse_fail_a: assert property (state == ST_CHECK && reject |-> s_refused)
    else $error("refused command did not report failure");
  refuse_quiet_a: assert property (state == ST_CHECK && reject |=> (!flash_prog && !flash_erase) [*2])
    else $error("refused command touched the array");
  ifb_user_a: assert property (flash_prog && flash_ifb && !writer_q |-> flash_addr[7:0] >= IFB_USER_FIRST)
    else $error("manufacturer bytes written outside programmer mode");
  erase_sector_a: assert property (flash_erase |-> flash_addr[SECTOR_BITS-1:0] == 10'h000)
    else $error("erase address not sector aligned");
  read_addr_a: assert property (state == ST_READ |-> flash_read && flash_addr == target[15:0])
    else $error("read used the wrong address");
  invalid_code_a: assert property (state == ST_CHECK && !cmd_valid |=> fail)
    else $error("unknown code did not fail");
  verify_flag_a: assert property (state == ST_VERIFY_WAIT |=> write_verify_mismatch == ($past(flash_rdata) != flash_data))
    else $error("write verify flag wrong");

endmodule

// ---- hdl/flash_ctrl_pkg.sv ----
// Constants shared by the flash command controller and its command timer.
// Assumes an 8-bit special register port from the CPU core and a byte-wide flash macro.
package flash_ctrl_pkg;

  // Special register addresses.
  localparam logic [15:0] OFS_ADDR_TOP = 16'hA012;
  localparam logic [15:0] OFS_COMMAND = 16'hA020;
  localparam logic [15:0] OFS_DATA = 16'hA021;
  localparam logic [15:0] OFS_ADDR_HIGH = 16'hA022;
  localparam logic [15:0] OFS_ADDR_LOW = 16'hA023;
  localparam logic [15:0] OFS_SCALER = 16'hA024;
  localparam logic [15:0] OFS_LOW_BOUND = 16'hA025;
  localparam logic [15:0] OFS_HIGH_BOUND = 16'hA026;

  // Values after reset.
  localparam logic [7:0] RST_ADDR = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [2:0] RST_TIMEOUT_SEL = 3'h4;
  localparam logic [4:0] RST_CMD_CODE = 5'h00;
  localparam logic [7:0] RST_SCALER = 8'h25;
  localparam logic [7:0] RST_LOW_BOUND = 8'hFF;
  localparam logic [7:0] RST_HIGH_BOUND = 8'h00;

  // Field positions in the command register.
  localparam int CMD_VERIFY_BIT = 7;
  localparam int CMD_FAIL_BIT = 5;
  localparam int CMD_SEL_LSB = 5;

  // One-hot command codes.
  localparam logic [4:0] CMD_MAIN_READ = 5'h10;
  localparam logic [4:0] CMD_MAIN_WRITE = 5'h08;
  localparam logic [4:0] CMD_MAIN_ERASE = 5'h04;
  localparam logic [4:0] CMD_IFB_READ = 5'h02;
  localparam logic [4:0] CMD_IFB_WRITE = 5'h01;

  // Array geometry.
  localparam int SECTOR_BITS = 10;
  localparam logic [7:0] IFB_USER_FIRST = 8'h40;
  localparam logic [7:0] HIGH_ZONE_BASE = 8'h80;
  localparam logic [1:0] PAGE_FIRST = 2'h0;
  localparam logic [1:0] PAGE_LAST = 2'h3;

  // Command durations in time-base ticks, indexed by the time-out select field.
  localparam logic [13:0] WRITE_TICKS [8] = '{14'd55, 14'd60, 14'd65, 14'd69, 14'd75, 14'd80, 14'd85, 14'd89};
  localparam logic [13:0] ERASE_TICKS [8] = '{14'd5435, 14'd5953, 14'd6452, 14'd6897,
                                              14'd7408, 14'd7906, 14'd8404, 14'd8889};

  typedef enum logic [2:0] {
    ST_IDLE, ST_CHECK, ST_READ, ST_READ_WAIT, ST_PROG, ST_VERIFY, ST_VERIFY_WAIT, ST_ERASE_DONE
  } state_t;

endpackage

// ---- testbench/embedded_flash_command_controller_tb.sv ----
// Self-checking bench for the flash command controller, driving its special register port.
// Assumes the flash array model beside it and inputs driven at the falling clock edge.
`timescale 1ns/1ps
module embedded_flash_command_controller_tb
  import flash_ctrl_pkg::*;
;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic fetch_req = 1'b0;
  logic writer_mode = 1'b0;
  logic corrupt = 1'b0;
  logic [15:0] sfr_addr = 16'h0000;
  logic [15:0] fetch_addr = 16'h0000;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata, fetch_data, flash_wdata, flash_rdata, rd;
  logic cpu_stall, flash_ifb, flash_read, flash_prog, flash_erase;
  logic [15:0] flash_addr, last_read_addr;
  int miscompares = 0;
  int checks_done = 0;
  int strobes = 0;
  int n;
  logic [15:0] reg_addrs [9] = '{OFS_ADDR_TOP, OFS_COMMAND, OFS_DATA, OFS_ADDR_HIGH, OFS_ADDR_LOW, OFS_SCALER,
                                 OFS_LOW_BOUND, OFS_HIGH_BOUND, 16'hA030};
  logic [7:0] reg_resets [9] = '{RST_ADDR, 8'h00, RST_DATA, RST_ADDR, RST_ADDR, RST_SCALER, RST_LOW_BOUND,
                                 RST_HIGH_BOUND, 8'h00};

  always #10 ref_clk = ~ref_clk;

  // Counts array strobe cycles so refused commands can be shown to leave the array alone.
  always @(posedge ref_clk) if (flash_prog | flash_erase) strobes <= strobes + 1;

  flash_cmd_ctrl dut (.ref_clk(ref_clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cpu_stall(cpu_stall), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_data(fetch_data), .writer_mode(writer_mode), .flash_addr(flash_addr),
    .flash_ifb(flash_ifb), .flash_read(flash_read), .flash_prog(flash_prog), .flash_erase(flash_erase),
    .flash_wdata(flash_wdata), .flash_rdata(flash_rdata));

  flash_array_model macro (.ref_clk(ref_clk), .flash_addr(flash_addr), .flash_ifb(flash_ifb),
    .flash_read(flash_read), .flash_prog(flash_prog), .flash_erase(flash_erase), .flash_wdata(flash_wdata),
    .corrupt(corrupt), .flash_rdata(flash_rdata), .last_read_addr(last_read_addr));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask

  task automatic rdreg(input logic [15:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask

  // Loads top:high:low address bytes and the data register.
  task automatic setaddr(input logic [7:0] t, input logic [7:0] h, input logic [7:0] l, input logic [7:0] d);
    wr(OFS_ADDR_TOP, t);
    wr(OFS_ADDR_HIGH, h);
    wr(OFS_ADDR_LOW, l);
    wr(OFS_DATA, d);
  endtask

  // Issues a command, measures the stall length, then reads back the status flags.
  task automatic op(input logic [7:0] c, input int stall_exp, input logic [7:0] flags);
    int i;
    logic [7:0] v;
    strobes = 0;
    wr(OFS_COMMAND, c);
    // The stall rises on the issuing edge, so the cycle already spent inside wr counts as well.
    n = (cpu_stall === 1'b1) ? 1 : 0;
    for (i = 0; i < 20000; i++) begin
      @(negedge ref_clk);
      if (cpu_stall === 1'b1) n++;
      else if (n > 0) break;
    end
    if (i == 20000) begin
      miscompares++;
      $display("BAD stall expected release seen none");
      conclude();
    end else begin
      if (stall_exp > 0) check("stall cycles", n[15:0], stall_exp[15:0]);
      rdreg(OFS_COMMAND, v);
      check("command flags", {8'h00, v}, {8'h00, flags});
      if (flags[5]) check("strobes", strobes[15:0], 16'h0000);
    end
  endtask

  initial begin
    repeat (10) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (3) @(negedge ref_clk);
    for (int k = 0; k < 9; k++) begin
      rdreg(reg_addrs[k], rd);
      check("reset value", {8'h00, rd}, {8'h00, reg_resets[k]});
    end
    wr(OFS_SCALER, 8'hFF);
    setaddr(8'h00, 8'h34, 8'h00, 8'hA5);
    op(8'h08, 2, 8'h28);
    wr(OFS_LOW_BOUND, 8'h00);
    for (int s = 0; s < 8; s++) begin
      setaddr(8'h00, 8'h34, s[7:0], 8'hA0 + s[7:0]);
      op({s[2:0], 5'h08}, 5 + int'(WRITE_TICKS[s]), 8'h08);
    end
    setaddr(8'h00, 8'h34, 8'h03, 8'h00);
    op(8'h10, 4, 8'h10);
    rdreg(OFS_DATA, rd);
    check("read data", {8'h00, rd}, 16'h00A3);
    check("read address", last_read_addr, 16'h3403);
    @(negedge ref_clk);
    fetch_addr = 16'h3405;
    fetch_req = 1'b1;
    @(negedge ref_clk);
    fetch_req = 1'b0;
    repeat (2) @(negedge ref_clk);
    check("fetch data", {8'h00, fetch_data}, 16'h00A5);
    setaddr(8'h00, 8'h38, 8'h00, 8'h5A);
    op(8'h08, 60, 8'h08);
    setaddr(8'h00, 8'h37, 8'hFF, 8'h00);
    op(8'h04, 3 + int'(ERASE_TICKS[0]), 8'h04);
    setaddr(8'h00, 8'h34, 8'h03, 8'h00);
    op(8'h10, 4, 8'h10);
    rdreg(OFS_DATA, rd);
    check("erased byte", {8'h00, rd}, 16'h00FF);
    setaddr(8'h00, 8'h38, 8'h00, 8'h00);
    op(8'h10, 4, 8'h10);
    rdreg(OFS_DATA, rd);
    check("next sector", {8'h00, rd}, 16'h005A);
    op(8'hE4, 3 + int'(ERASE_TICKS[7]), 8'h04);
    setaddr(8'h00, 8'h80, 8'h00, 8'h11);
    op(8'h08, 2, 8'h28);
    setaddr(8'h01, 8'h00, 8'h00, 8'h11);
    op(8'h10, 2, 8'h30);
    op(8'h03, 2, 8'h23);
    rdreg(OFS_COMMAND, rd);
    check("fail kept", {8'h00, rd}, 16'h0023);
    setaddr(8'h00, 8'h20, 8'h00, 8'h11);
    op(8'h10, 4, 8'h10);
    setaddr(8'h00, 8'h00, 8'h3F, 8'h3C);
    op(8'h01, 2, 8'h21);
    setaddr(8'h00, 8'h00, 8'h40, 8'h3C);
    op(8'h01, 60, 8'h01);
    op(8'h02, 4, 8'h02);
    rdreg(OFS_DATA, rd);
    check("block data", {8'h00, rd}, 16'h003C);
    writer_mode = 1'b1;
    setaddr(8'h00, 8'h00, 8'h20, 8'h77);
    op(8'h01, 60, 8'h01);
    writer_mode = 1'b0;
    corrupt = 1'b1;
    setaddr(8'h00, 8'h50, 8'h00, 8'h0F);
    op(8'h08, 60, 8'h88);
    corrupt = 1'b0;
    // half rate time base, one tick every two clocks.
    wr(OFS_SCALER, 8'h7F);
    setaddr(8'h00, 8'h50, 8'h01, 8'hF0);
    op(8'h08, 0, 8'h08);
    check("half rate", {15'h0000, (n >= 113 && n <= 117)}, 16'h0001);
    conclude();
  end
endmodule

// ---- testbench/flash_array_model.sv ----
// Behavioural flash macro: 64K main array in 1024-byte sectors plus a 256-byte information block.
// Assumes registered strobes from the controller on ref_clk; read data is returned one clock later.
`timescale 1ns/1ps
module flash_array_model (
  input wire logic ref_clk,
  input wire logic [15:0] flash_addr,
  input wire logic flash_ifb,
  input wire logic flash_read,
  input wire logic flash_prog,
  input wire logic flash_erase,
  input wire logic [7:0] flash_wdata,
  input wire logic corrupt,
  output logic [7:0] flash_rdata,
  output logic [15:0] last_read_addr
);
  logic [7:0] main_mem [65536];
  logic [7:0] ifb_mem [256];
  logic prog_q = 1'b0;
  logic erase_q = 1'b0;

  // Both arrays start erased.
  initial begin
    flash_rdata = 8'h00;
    last_read_addr = 16'h0000;
    for (int i = 0; i < 65536; i++) main_mem[i] = 8'hFF;
    for (int i = 0; i < 256; i++) ifb_mem[i] = 8'hFF;
  end

  // Programming only clears bits, as real cells do; corrupt flips bit 0 to provoke a verify miss.
  // program, sector erase and read port.
  always @(posedge ref_clk) begin
    prog_q <= flash_prog;
    erase_q <= flash_erase;
    if (flash_prog && !prog_q && flash_ifb) ifb_mem[flash_addr[7:0]] <= ifb_mem[flash_addr[7:0]] & (flash_wdata ^ {7'h00, corrupt});
    if (flash_prog && !prog_q && !flash_ifb) main_mem[flash_addr] <= main_mem[flash_addr] & (flash_wdata ^ {7'h00, corrupt});
    if (flash_erase && !erase_q && !flash_ifb) begin
      for (int j = 0; j < 1024; j++) main_mem[{flash_addr[15:10], j[9:0]}] <= 8'hFF;
    end
    // Outside a read the data lines show a changing pattern, so stale data is never mistaken for valid.
    if (flash_read) begin
      flash_rdata <= flash_ifb ? ifb_mem[flash_addr[7:0]] : main_mem[flash_addr];
      last_read_addr <= flash_addr;
    end else begin
      flash_rdata <= ~flash_rdata;
    end
  end
endmodule
